// ### sfh_map.svh
// Constants of the serial flash host: register map, fields, opcodes, timing.
// Assumes a 100 MHz system clock and word-indexed Avalon-MM addressing.
`ifndef SFH_MAP_SVH
`define SFH_MAP_SVH

// Register indices (Avalon word address)
`define SFH_REG_CTRL    3'h0
`define SFH_REG_ADDR    3'h1
`define SFH_REG_TXCFG   3'h2
`define SFH_REG_STATUS  3'h3
`define SFH_REG_RDATA   3'h4

// Control and status register fields
`define SFH_CTRL_HAS_ADDR 8
`define SFH_CTRL_HAS_TX   9
`define SFH_CTRL_START    10
`define SFH_STAT_ERR      6

// Opcodes
`define SFH_OP_READ     8'h03
`define SFH_OP_FAST     8'h0B
`define SFH_OP_DOUT     8'h3B
`define SFH_OP_DIO      8'hBB
`define SFH_OP_QIO      8'hEB
`define SFH_OP_QOUT     8'h6B
`define SFH_OP_SFDP     8'h5A
`define SFH_OP_QPP      8'h32
`define SFH_OP_PP       8'h02
`define SFH_OP_QEN      8'h38
`define SFH_OP_QEXIT    8'hFF
`define SFH_OP_RARM     8'h66
`define SFH_OP_RST      8'h99
`define SFH_OP_WLSET    8'h06
`define SFH_OP_WLCLR    8'h04
`define SFH_OP_RDSR     8'h05
`define SFH_OP_WRSR     8'h01
`define SFH_OP_E1K      8'h46
`define SFH_OP_E2K      8'h24
`define SFH_OP_E4K      8'h20
`define SFH_OP_E32K     8'h52
`define SFH_OP_E64K     8'hD8
`define SFH_OP_CE1      8'hC7
`define SFH_OP_CE2      8'h60

// Timing and reset status value
`define SFH_CLK_MHZ         100
`define SFH_RST_RECOV_NS    28000
`define SFH_CS_GAP_CYC      4
`define SFH_RST_VAL         8'h00

`endif

// ### sfh_pkg.sv
// Types of the serial flash host.
// Assumes sfh_map.svh supplies all numeric constants.
package sfh_pkg;

    typedef enum logic [2:0] {
        PH_IDLE, PH_OPC, PH_ADR, PH_DUM, PH_TXD, PH_RXD, PH_GAP
    } sfh_phase_e;

    typedef struct packed {
        logic [3:0]  dq_s1;
        logic [3:0]  dq_s2;
        logic        bus_wait;
        logic [31:0] bus_rdata;
        logic [7:0]  op;
        logic        has_addr;
        logic        has_tx;
        logic [7:0]  rx_len;
        logic [23:0] addr;
        logic [7:0]  tx_byte;
        logic [7:0]  perf;
        sfh_phase_e  ph;
        logic [7:0]  div;
        logic        sck;
        logic        cs_n;
        logic [3:0]  dq_o;
        logic [3:0]  dq_oe_n;
        logic [31:0] sh;
        logic [7:0]  rx;
        logic [5:0]  cnt;
        logic [2:0]  w;
        logic [2:0]  wa;
        logic [2:0]  wd;
        logic [5:0]  dum;
        logic [7:0]  rxn;
        logic [11:0] gap;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        quad_cmd_mode;
        logic        cont_mode;
        logic        reset_arm;
        logic        write_enable_latch;
        logic        small_erase;
        logic        err;
    } sfh_state_s;

endpackage

// ### sfh_host.sv
// Host controller that drives a serial/quad flash over its pins.
// Assumes one 100 MHz clock and an Avalon-MM master.
//
// Functional notes
// R1 - Power-down release ID repeats while selected.
// R2 - Order byte 00h: maker first; 01h: device first.
// R3 - JEDEC ID: maker, type, capacity.
// R4 - Reads: 24-bit address, streamed data, per-opcode lanes.
// R5 - Dummies 0 for 03h, 4 for BBh, else 8; quad allows 0Bh, EBh.
// R6 - EBh: 2 dummy clocks carry enhance indicator.
// R7 - Read acceptance depends on command mode.
// R8 - After 38h all commands use 4 lanes.
// R9 - Quad mode forbids 03h, 3Bh, BBh, 32h.
// R10 - FFh returns quad mode to single-bit.
// R11 - FFh is no quad reset in single-bit mode.
// R12 - FFh leaves continuous read first, then quad.
// R13 - Reset: 66h frame, then 99h frame.
// R14 - 99h acts only right after 66h.
// R15 - Reset clears status to 00h.
// R16 - Reset aborts program or erase.
// R17 - Wait 28 us after reset.
// R18 - Reset pair in current width; quad in continuous read.
// R19 - Reset pair works in any mode; back to single-bit.
// R20 - Reset keeps deep power-down.
// R21 - No reset during 1K, 2K, 4K, 32K erase.
// R22 - 06h sets write latch, needed before program, erase, status write.
// R23 - Bytes MSB first.
// R24 - Opcode: 8 clocks single, 2 quad.
// R25 - Write latch clears after status write, program, erase.
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "sfh_map.svh"

module sfh_host
    import sfh_pkg::*;
#(
    parameter int        SCK_HALF = 4,
    parameter logic [7:0] ENH_CODE = 8'hA0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             spi_sck,
    output logic             spi_cs_n,
    input  wire logic [3:0]  spi_dq_i,
    output logic [3:0]       spi_dq_o,
    output logic [3:0]       spi_dq_oe_n
);

    localparam int RECOV_CYC = (`SFH_RST_RECOV_NS * `SFH_CLK_MHZ + 999) / 1000;

    sfh_state_s st_q;
    sfh_state_s st_d;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Clocks needed for one byte at a lane width
    function automatic logic [5:0] clk_byte(input logic [2:0] w);
        clk_byte = (w == 3'd4) ? 6'd2 : (w == 3'd2) ? 6'd4 : 6'd8;
    endfunction

    // Address lane width
    function automatic logic [2:0] addr_w(input logic [7:0] op, input logic qm);
        addr_w = (qm || op == `SFH_OP_QIO) ? 3'd4 : (op == `SFH_OP_DIO) ? 3'd2 : 3'd1;  // [R4] [R8]
    endfunction
    // Data lane width
    function automatic logic [2:0] data_w(input logic [7:0] op, input logic qm);
        data_w = (qm || op == `SFH_OP_QIO || op == `SFH_OP_QOUT || op == `SFH_OP_QPP) ? 3'd4 :
                 (op == `SFH_OP_DIO || op == `SFH_OP_DOUT) ? 3'd2 : 3'd1;  // [R4]
    endfunction

    // Dummy clocks before read data
    function automatic logic [5:0] dummy_n(input logic [7:0] op);
        case (op)
            `SFH_OP_FAST, `SFH_OP_DOUT, `SFH_OP_QIO,
            `SFH_OP_QOUT, `SFH_OP_SFDP: dummy_n = 6'd8;            // [R5]
            `SFH_OP_DIO:                dummy_n = 6'd4;            // [R5]
            default:                    dummy_n = 6'd0;
        endcase
    endfunction

    // Output lanes, top bits first
    function automatic logic [3:0] lanes(input logic [31:0] sh, input logic [2:0] w);
        lanes = (w == 3'd4) ? sh[31:28] : (w == 3'd2) ? {2'b11, sh[31:30]} : {3'b110, sh[31]};  // [R23]
    endfunction
    // Output enables, low while driving
    function automatic logic [3:0] oe_for(input logic [2:0] w, input logic drv);
        oe_for = (w == 3'd4) ? (drv ? 4'h0 : 4'hF) : (w == 3'd2) ? (drv ? 4'h0 : 4'h3) : 4'h2;
    endfunction
    // Shift sampled lanes into the receive byte
    function automatic logic [7:0] samp(input logic [7:0] rx, input logic [3:0] dq,
                                       input logic [2:0] w);
        samp = (w == 3'd4) ? {rx[3:0], dq} : (w == 3'd2) ? {rx[5:0], dq[1:0]} : {rx[6:0], dq[1]};
    endfunction

    // Next phase after the current one ends
    function automatic sfh_phase_e next_ph(input sfh_phase_e cur, input logic ha,
                                           input logic [5:0] dm, input logic tx,
                                           input logic [7:0] rn);
        next_ph = PH_GAP;
        if (cur == PH_OPC && ha)
            next_ph = PH_ADR;
        else if ((cur == PH_OPC || cur == PH_ADR) && dm != 6'd0)
            next_ph = PH_DUM;
        else if (cur != PH_TXD && cur != PH_RXD && tx)
            next_ph = PH_TXD;
        else if (cur != PH_RXD && rn != 8'd0)
            next_ph = PH_RXD;
    endfunction

    // Commands that need the write latch
    function automatic logic needs_wel(input logic [7:0] op);
        case (op)
            `SFH_OP_PP, `SFH_OP_QPP, `SFH_OP_WRSR, `SFH_OP_E1K, `SFH_OP_E2K,
            `SFH_OP_E4K, `SFH_OP_E32K, `SFH_OP_E64K, `SFH_OP_CE1,
            `SFH_OP_CE2: needs_wel = 1'b1;
            default:     needs_wel = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic       go;
    logic       pop;
    logic       clr_err;
    logic       refuse;
    logic       ld;
    sfh_phase_e nph;

    always_comb begin
        st_d    = st_q;
        go      = 1'b0;
        pop     = 1'b0;
        clr_err = 1'b0;
        refuse  = 1'b0;
        ld      = 1'b0;
        nph     = PH_GAP;
        // Pin synchroniser
        st_d.dq_s1 = spi_dq_i;
        st_d.dq_s2 = st_q.dq_s1;

        // Avalon slave: answer one cycle after the request
        st_d.bus_wait = 1'b1;
        if ((avs_read || avs_write) && st_q.bus_wait) begin
            st_d.bus_wait  = 1'b0;
            case (avs_address)
                `SFH_REG_CTRL:   st_d.bus_rdata = {8'h00, st_q.rx_len, 5'h00, 1'b0,
                                                   st_q.has_tx, st_q.has_addr, st_q.op};
                `SFH_REG_ADDR:   st_d.bus_rdata = {8'h00, st_q.addr};
                `SFH_REG_TXCFG:  st_d.bus_rdata = {16'h0000, st_q.perf, st_q.tx_byte};
                `SFH_REG_STATUS: st_d.bus_rdata = {24'h00_0000, st_q.rvalid, st_q.err,
                                                   st_q.small_erase, st_q.write_enable_latch,
                                                   st_q.reset_arm, st_q.cont_mode,
                                                   st_q.quad_cmd_mode, st_q.ph != PH_IDLE};
                `SFH_REG_RDATA:  st_d.bus_rdata = {24'h00_0000, st_q.rdata};
                default:         st_d.bus_rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write && !st_q.bus_wait) begin
            case (avs_address)
                `SFH_REG_CTRL: begin
                    st_d.op       = avs_writedata[7:0];
                    st_d.has_addr = avs_writedata[`SFH_CTRL_HAS_ADDR];
                    st_d.has_tx   = avs_writedata[`SFH_CTRL_HAS_TX];
                    st_d.rx_len   = avs_writedata[23:16];
                    go            = avs_writedata[`SFH_CTRL_START];
                end
                `SFH_REG_ADDR:   st_d.addr = avs_writedata[23:0];
                `SFH_REG_TXCFG: begin
                    st_d.tx_byte = avs_writedata[7:0];
                    st_d.perf    = avs_writedata[15:8];
                end
                `SFH_REG_STATUS: clr_err = avs_writedata[`SFH_STAT_ERR];
                default: ;
            endcase
        end
        pop = avs_read && !st_q.bus_wait && avs_address == `SFH_REG_RDATA;
        if (pop) st_d.rvalid = 1'b0;
        if (clr_err) st_d.err = 1'b0;

        // Command engine
        case (st_q.ph)
            PH_IDLE: begin
                if (go) begin
                    // Host-side checks before a frame is launched
                    if (st_q.quad_cmd_mode && (st_d.op == `SFH_OP_READ || st_d.op == `SFH_OP_DOUT ||
                        st_d.op == `SFH_OP_DIO || st_d.op == `SFH_OP_QPP))
                        refuse = 1'b1;                           // [R7] [R9] [R5]
                    if (st_d.op == `SFH_OP_RST && (!st_q.reset_arm || st_q.small_erase))
                        refuse = 1'b1;                           // [R13] [R14] [R21]
                    if (needs_wel(st_d.op) && !st_q.write_enable_latch)
                        refuse = 1'b1;                           // [R22]
                    if (st_q.cont_mode && st_d.op != `SFH_OP_QIO && st_d.op != `SFH_OP_QEXIT &&
                        st_d.op != `SFH_OP_RARM && st_d.op != `SFH_OP_RST)
                        refuse = 1'b1;                           // [R12] [R18]
                    if (refuse) begin
                        st_d.err = 1'b1;
                    end else begin
                        st_d.wa   = addr_w(st_d.op, st_q.quad_cmd_mode);
                        st_d.wd   = data_w(st_d.op, st_q.quad_cmd_mode);
                        st_d.dum  = dummy_n(st_d.op);
                        st_d.rxn  = st_d.rx_len;
                        st_d.cs_n = 1'b0;
                        st_d.sck  = 1'b0;
                        st_d.div  = 8'd0;
                        st_d.reset_arm = (st_d.op == `SFH_OP_RARM);   // [R14]
                        if (st_d.op == `SFH_OP_E1K || st_d.op == `SFH_OP_E2K ||
                            st_d.op == `SFH_OP_E4K || st_d.op == `SFH_OP_E32K)
                            st_d.small_erase = 1'b1;  // [R21]
                        if (st_q.cont_mode && st_d.op == `SFH_OP_QIO) begin
                            // Continuous read resumes at the address
                            ld  = 1'b1;
                            nph = PH_ADR;
                        end else begin
                            st_d.ph = PH_OPC;
                            st_d.w  = (st_q.quad_cmd_mode || st_q.cont_mode) ? 3'd4 : 3'd1;  // [R18]
                            st_d.cnt = clk_byte(st_d.w);                 // [R24]
                            st_d.sh  = {st_d.op, 24'h00_0000};           // [R23]
                            st_d.dq_o    = lanes(st_d.sh, st_d.w);
                            st_d.dq_oe_n = oe_for(st_d.w, 1'b1);
                        end
                        // Mode tracking follows the device
                        case (st_d.op)
                            `SFH_OP_QEN:   st_d.quad_cmd_mode = 1'b1;         // [R8]
                            `SFH_OP_QEXIT: begin
                                if (st_q.cont_mode)
                                    st_d.cont_mode = 1'b0;                    // [R12]
                                else
                                    st_d.quad_cmd_mode = 1'b0;                // [R10] [R11]
                            end
                            `SFH_OP_RST: begin
                                st_d.quad_cmd_mode      = 1'b0;               // [R19]
                                st_d.cont_mode          = 1'b0;
                                st_d.write_enable_latch = `SFH_RST_VAL == 8'h00 ? 1'b0 : 1'b1; // [R15]
                            end
                            `SFH_OP_WLSET: st_d.write_enable_latch = 1'b1;    // [R22]
                            `SFH_OP_WLCLR: st_d.write_enable_latch = 1'b0;
                            `SFH_OP_QIO:   st_d.cont_mode = (st_d.perf == ENH_CODE);  // [R6]
                            default: begin
                                if (needs_wel(st_d.op))
                                    st_d.write_enable_latch = 1'b0;           // [R25]
                            end
                        endcase
                    end
                end
            end
            PH_GAP: begin
                // Select high gap, stretched to the recovery time after reset
                if (st_q.gap == 12'd0)
                    st_d.ph = PH_IDLE;
                else
                    st_d.gap = st_q.gap - 12'd1;
            end
            default: begin
                if (st_q.div == 8'(SCK_HALF - 1)) begin
                    if (!st_q.sck) begin
                        // Rising edge: sample read lanes
                        st_d.div = 8'd0;
                        st_d.sck = 1'b1;
                        if (st_q.ph == PH_RXD)
                            st_d.rx = samp(st_q.rx, st_q.dq_s2, st_q.w);
                    end else if (!(st_q.ph == PH_RXD && st_q.cnt == 6'd1 && st_d.rvalid)) begin
                        // Falling edge: shift out, unless the read byte is unclaimed
                        st_d.div = 8'd0;
                        st_d.sck = 1'b0;
                        st_d.cnt = st_q.cnt - 6'd1;
                        st_d.sh  = st_q.sh << st_q.w;
                        st_d.dq_o = lanes(st_d.sh, st_q.w);
                        if (st_q.ph == PH_DUM && st_d.cnt == 6'd6)
                            st_d.dq_oe_n = oe_for(st_q.w, 1'b0);         // [R6]
                        if (st_q.cnt == 6'd1) begin
                            if (st_q.ph == PH_RXD) begin
                                st_d.rdata  = st_q.rx;                   // [R1] [R2] [R3] [R4]
                                st_d.rvalid = 1'b1;
                                st_d.rxn    = st_q.rxn - 8'd1;
                                if (st_q.op == `SFH_OP_RDSR) begin
                                    st_d.write_enable_latch = st_q.rx[1];
                                    if (!st_q.rx[0])
                                        st_d.small_erase = 1'b0;         // [R21]
                                end
                                if (st_q.rxn != 8'd1)
                                    st_d.cnt = clk_byte(st_q.w);
                                else begin
                                    ld  = 1'b1;
                                    nph = PH_GAP;
                                end
                            end else begin
                                ld  = 1'b1;
                                nph = next_ph(st_q.ph, st_q.has_addr, st_q.dum,
                                              st_q.has_tx, st_q.rxn);
                            end
                        end
                    end
                end else begin
                    st_d.div = st_q.div + 8'd1;
                end
            end
        endcase

        // Load the next phase
        if (ld) begin
            st_d.ph = nph;
            case (nph)
                PH_ADR: begin
                    st_d.w   = st_d.wa;
                    st_d.cnt = 6'(3 * clk_byte(st_d.wa));                // [R4]
                    st_d.sh  = {st_d.addr, 8'h00};
                    st_d.dq_oe_n = oe_for(st_d.wa, 1'b1);
                end
                PH_DUM: begin
                    st_d.w   = (st_d.op == `SFH_OP_QIO) ? 3'd4 : st_d.wa;
                    st_d.cnt = st_d.dum;                                 // [R5]
                    st_d.sh  = {st_d.perf, 24'h00_0000};
                    st_d.dq_oe_n = oe_for(st_d.w, st_d.op == `SFH_OP_QIO);  // [R6]
                end
                PH_TXD: begin
                    st_d.w   = st_d.wd;
                    st_d.cnt = clk_byte(st_d.wd);
                    st_d.sh  = {st_d.tx_byte, 24'h00_0000};
                    st_d.dq_oe_n = oe_for(st_d.wd, 1'b1);
                end
                PH_RXD: begin
                    st_d.w   = st_d.wd;
                    st_d.cnt = clk_byte(st_d.wd);
                    st_d.dq_oe_n = oe_for(st_d.wd, 1'b0);
                end
                default: begin
                    st_d.cs_n    = 1'b1;
                    st_d.sck     = 1'b0;
                    st_d.dq_oe_n = 4'hF;
                    st_d.gap = 12'(`SFH_CS_GAP_CYC) +
                               ((st_d.op == `SFH_OP_RST) ? 12'(RECOV_CYC) : 12'd0);  // [R17] [R16]
                end
            endcase
            st_d.dq_o = lanes(st_d.sh, st_d.w);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_q          <= '0;
            st_q.cs_n     <= 1'b1;
            st_q.dq_oe_n  <= 4'hF;
            st_q.bus_wait <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata    = st_q.bus_rdata;
    assign avs_waitrequest = st_q.bus_wait;
    assign spi_sck         = st_q.sck;
    assign spi_cs_n        = st_q.cs_n;
    assign spi_dq_o        = st_q.dq_o;
    assign spi_dq_oe_n     = st_q.dq_oe_n;

endmodule

// ### sfh_host_props.sv
// Checker of the host ports: bus handshake and link framing.
// Assumes binding into the host with its link clock divider.
`timescale 1ns/10ps
module sfh_host_props #(
    parameter int SCK_HALF = 4
) (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        spi_sck,
    input wire logic        spi_cs_n,
    input wire logic [3:0]  spi_dq_i,
    input wire logic [3:0]  spi_dq_o,
    input wire logic [3:0]  spi_dq_oe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [7:0] lo_q;
    logic [9:0] nck_q;
    // Low cycles of the link clock, link clock rises in a frame
    always_ff @(posedge clk_sys) begin
        lo_q <= (!rst_b || spi_sck) ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
        nck_q <= (!rst_b || spi_cs_n) ? 10'h000 : nck_q + {9'h000, $rose(spi_sck)};
    end
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("answer not one cycle");
    AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    AST_UNMAPPED: assert property (!avs_waitrequest && $past(avs_read) && $past(avs_address) > 3'h4 |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_SCK_IDLE: assert property (spi_cs_n |-> !spi_sck)
        else $error("link clock moves outside frame");
    AST_FRAME_CLKS: assert property ($rose(spi_cs_n) |-> nck_q >= 10'd2 && !nck_q[0])
        else $error("frame clock count broken");
    AST_CS_GAP: assert property ($rose(spi_cs_n) |-> spi_cs_n[*4])
        else $error("select gap too short");
    AST_SCK_LOW: assert property ($rose(spi_sck) |-> lo_q >= SCK_HALF)
        else $error("link clock low phase short");
    AST_DQ_STABLE: assert property ($rose(spi_sck) |-> $stable(spi_dq_o) && $stable(spi_dq_oe_n))
        else $error("lanes change at sampling edge");
endmodule
bind sfh_host sfh_host_props #(.SCK_HALF(SCK_HALF)) u_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_dq_i(spi_dq_i), .spi_dq_o(spi_dq_o), .spi_dq_oe_n(spi_dq_oe_n));

// ### sfh_flash_mdl.sv
// Flash device model: ID, status, quad mode, reset pair, write latch.
// Assumes mode 0 clocking and lane levels resolved by the bench.
`timescale 1ns/10ps
module sfh_flash_mdl #(
    parameter logic [23:0] ID_CODE = 24'h5A_A512 // Arbitrary identity value
) (
    input  wire logic       spi_sck,
    input  wire logic       spi_cs_n,
    input  wire logic [3:0] dq_i,
    output logic [3:0]      dq_o,
    output logic [3:0]      dq_oe_n
);
    logic [7:0]  op_q;
    logic [7:0]  sr_q = 8'h00;
    logic        quad_q = 1'b0;
    logic        arm_q = 1'b0;
    logic [23:0] sh_q;
    int          n_q = 0;
    initial dq_oe_n = 4'hF;
    initial dq_o = 4'h0;
    // Opcode capture, MSB first, 8 clocks single or 2 quad
    always @(posedge spi_sck) begin
        if (!spi_cs_n && n_q < (quad_q ? 2 : 8)) begin
            op_q = quad_q ? {op_q[3:0], dq_i} : {op_q[6:0], dq_i[0]};
            n_q = n_q + 1;
            sh_q = (op_q == 8'h9F) ? ID_CODE : {3{sr_q}};
        end
    end
    // Answer rotates so it repeats until select rises
    always @(negedge spi_sck) begin
        if (!spi_cs_n && n_q >= (quad_q ? 2 : 8)) begin
            dq_oe_n = quad_q ? 4'h0 : 4'hD;
            dq_o = quad_q ? sh_q[23:20] : {2'b00, sh_q[23], 1'b0};
            sh_q = quad_q ? {sh_q[19:0], sh_q[23:20]} : {sh_q[22:0], sh_q[23]};
        end
    end
    // Frame end: release lanes and act on the command
    always @(posedge spi_cs_n) begin
        dq_oe_n = 4'hF;
        if (n_q == (quad_q ? 2 : 8)) begin
            if (op_q == 8'h99 && arm_q) begin
                sr_q = 8'h00;
                quad_q = 1'b0;
            end
            if (op_q == 8'h38) quad_q = 1'b1;
            if (op_q == 8'hFF) quad_q = 1'b0;
            if (op_q == 8'h06) sr_q[1] = 1'b1;
            arm_q = (op_q == 8'h66);
        end
        n_q = 0;
    end
endmodule

// ### testbench.sv
// Bench: Avalon register tasks run flash frames and compare results.
// Assumes the host register map and default link clock divider.
`timescale 1ns/10ps
`include "sfh_map.svh"
module testbench;
    localparam logic [23:0] ID = 24'h5A_A512; // Arbitrary identity value
    localparam logic [31:0] Z = 32'h0000_0000;
    localparam logic [23:0] N = 24'h00_0000;
    logic [7:0]  bad [4] = '{8'h03, 8'h3B, 8'hBB, 8'h32};
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [2:0]  avs_address = 3'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = Z;
    logic [31:0] avs_readdata, rv;
    logic        avs_waitrequest, spi_sck, spi_cs_n;
    logic [3:0]  h_o, h_oe_n, f_o, f_oe_n, dq;
    int          errors = 0;
    int          comparisons = 0;
    longint      dur;
    // Released lanes show the inverse of the model value
    assign dq = (~h_oe_n & h_o) | (~f_oe_n & f_o) | (h_oe_n & f_oe_n & ~f_o);
    always #5 clk_sys = ~clk_sys;
    sfh_host DUT (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_dq_i(dq),
        .spi_dq_o(h_o), .spi_dq_oe_n(h_oe_n));
    sfh_flash_mdl #(.ID_CODE(ID)) u_mdl (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .dq_i(dq), .dq_o(f_o),
        .dq_oe_n(f_oe_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One Avalon access held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [2:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic st(input logic [7:0] exp);
        bus(1'b1, `SFH_REG_STATUS, Z);
        chk(rv & 32'h0000_007F, {24'h00_0000, exp});
    endtask
    task automatic clr;
        bus(1'b0, `SFH_REG_STATUS, 32'h0000_0040);
    endtask
    // Launch a frame, compare each received byte, wait for idle
    task automatic frame(input logic [7:0] op, input int n, input logic [23:0] exp);
        longint t0;
        bus(1'b0, `SFH_REG_CTRL, {8'h00, n[7:0], 8'h04, op});
        for (int i = 0; i < n; i++) begin
            do bus(1'b1, `SFH_REG_STATUS, Z); while (rv[7] !== 1'b1);
            bus(1'b1, `SFH_REG_RDATA, Z);
            chk({24'h00_0000, rv[7:0]}, {24'h00_0000, exp[23-8*i -: 8]});
        end
        t0 = $time;
        do bus(1'b1, `SFH_REG_STATUS, Z); while (rv[0] !== 1'b0);
        dur = ($time - t0) / 10;
    endtask
    task automatic summarize;
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #800_000;
        errors++;
        summarize;
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        st(8'h00);
        bus(1'b1, 3'h7, 32'hFFFF_FFFF);
        chk(rv, Z);
        frame(8'h9F, 3, ID);
        frame(8'h20, 0, N);
        st(8'h40);
        clr;
        frame(8'h06, 0, N);
        frame(8'h05, 2, 24'h02_0200);
        frame(8'h99, 0, N);
        st(8'h50);
        clr;
        frame(8'h66, 0, N);
        frame(8'h06, 0, N);
        frame(8'h99, 0, N);
        st(8'h50);
        clr;
        frame(8'h20, 0, N);
        frame(8'h66, 0, N);
        frame(8'h99, 0, N);
        st(8'h68);
        clr;
        frame(8'h38, 0, N);
        st(8'h22);
        frame(8'h05, 1, 24'h02_0000);
        foreach (bad[i]) begin
            frame(bad[i], 0, N);
            st(8'h52);
            clr;
        end
        frame(8'hFF, 0, N);
        st(8'h10);
        frame(8'h9F, 3, ID);
        frame(8'hFF, 0, N);
        st(8'h10);
        frame(8'h38, 0, N);
        frame(8'h66, 0, N);
        frame(8'h99, 0, N);
        chk({31'h0000_0000, dur >= 2800}, 32'h0000_0001);
        st(8'h00);
        frame(8'h05, 1, N);
        summarize;
    end
endmodule
